// ===== hdl/companion_defs.vh
`ifndef COMPANION_DEFS_VH
`define COMPANION_DEFS_VH

// Register addresses
`define ADDR_WDOG_CTRL   8'h0A
`define ADDR_COMP_CTRL   8'h0B
`define ADDR_EVT_CTRL    8'h0C
`define ADDR_CTRA_LO     8'h0D
`define ADDR_CTRA_HI     8'h0E
`define ADDR_CTRB_LO     8'h0F
`define ADDR_CTRB_HI     8'h10
`define ADDR_SERIAL_LO   8'h11
`define ADDR_SERIAL_HI   8'h18

// Event counter control fields
`define EVT_SNAP_BIT     3
`define EVT_CASC_BIT     2
`define EVT_BPOL_BIT     1
`define EVT_APOL_BIT     0

// Companion control fields
`define COMP_LOCK_BIT    7
`define COMP_PROT_HI     4
`define COMP_PROT_LO     3
`define COMP_CHG_BIT     2
`define COMP_TRIP_HI     1
`define COMP_TRIP_LO     0

// Watchdog control fields
`define WDOG_EN_BIT      7
`define WDOG_PER_HI      4
`define WDOG_PER_LO      0

// Array protection codes
`define PROT_NONE        2'h0
`define PROT_QUARTER     2'h1
`define PROT_HALF        2'h2
`define PROT_FULL        2'h3

// Reset values
`define RST_BYTE         8'h00
`define RST_SERIAL       64'h0000000000000000
`define RD_UNMAPPED      8'h00
`define RST_COUNT        16'h0000
`define RST_TRIP         2'h0
`define RST_PERIOD       5'h00
`define RST_BIT          1'b0

// Reserved fields, always stored and read as zero
`define COMP_RSVD_HI     6
`define COMP_RSVD_LO     5
`define RSVD_PAIR        2'h0
`define RSVD_NIBBLE      4'h0
`define SERIAL_IDX_BIAS  3'h1

// Cycles the pin synchroniser needs before its edges mean anything
`define SYNC_FILL_RST    2'h0
`define SYNC_FILL_STEP   2'h1
`define SYNC_FILL_DONE   2'h3

`endif

// ===== hdl/edge_counter.v
`timescale 1ns/1ps
`default_nettype none
`include "companion_defs.vh"

module edge_counter #(
    parameter W = 16
) (
    input  wire         sys_clk,
    input  wire         reset,
    input  wire         pinIn,
    input  wire         risingSel,
    input  wire         cascadeMode,
    input  wire         extStep,
    input  wire         wrLo,
    input  wire         wrHi,
    input  wire [7:0]   wrData,
    output wire [W-1:0] count,
    output wire         carry
);
    reg         sync1_reg;
    reg         sync2_reg;
    reg         prev_reg;
    reg [1:0]   fill_reg;
    wire        settled;
    reg [W-1:0] count_reg;
    reg [W-1:0] count_next;
    wire        rise;
    wire        fall;
    wire        step;

    // Pin is asynchronous; two stages before the edge detector
    always @(posedge sys_clk) begin
        if (reset) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            prev_reg  <= 1'b0;
            fill_reg  <= `SYNC_FILL_RST;
        end else begin
            sync1_reg <= pinIn;
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
            if (!settled) begin
                fill_reg <= fill_reg + `SYNC_FILL_STEP;
            end
        end
    end

    // Edges ignored until the chain is full, or a pin resting high looks like a rise
    assign settled = (fill_reg == `SYNC_FILL_DONE);
    assign rise  = settled & sync2_reg & ~prev_reg;
    assign fall  = settled & ~sync2_reg & prev_reg;
    // Own pin polarity ignored in cascade, stepped by the lower counter
    assign step  = cascadeMode ? extStep : (risingSel ? rise : fall); // see RULE1 RULE2 RULE3
    assign carry = step & (&count_reg); // see RULE4
    assign count = count_reg;

    always @* begin
        count_next = count_reg;
        if (step) begin
            count_next = count_reg + {{(W-1){1'b0}}, 1'b1};
        end
        // A host load wins over a coincident edge in the byte it writes; the other byte still takes the step
        if (wrLo) begin
            count_next[7:0] = wrData;
        end
        if (wrHi) begin
            count_next[W-1:8] = wrData[W-9:0];
        end
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            count_reg <= {W{1'b0}};
        end else begin
            count_reg <= count_next;
        end
    end
endmodule
`default_nettype wire

// ===== hdl/companion_control_regs.v
// What this block does
// RULE1: Counter B counts falling edges when its polarity bit is 0, rising when 1.
// RULE2: Counter B polarity bit is ignored during cascade but keeps its stored value.
// RULE3: Counter A counts falling edges when its polarity bit is 0, rising when 1.
// RULE4: Cascade joins both counters; B holds upper half, A's input drives counting.
// RULE5: Serial lock makes serial bytes and itself read-only; lock never clears. Here reset clears the lock.
// RULE6: Backup charge enable bit turns trickle charge current on or off.
// RULE7: Protection field blocks array writes: none, lower quarter, lower half, all.
`timescale 1ns/1ps
`default_nettype none
`include "companion_defs.vh"

module companion_control_regs #(
    parameter ARRAY_AW = 15
) (
    input  wire                sys_clk,
    input  wire                reset,
    input  wire [7:0]          regAddr,
    input  wire [7:0]          regWrData,
    input  wire                regWrEn,
    input  wire                regRdEn,
    output reg  [7:0]          regRdData,
    input  wire                ctrAPin,
    input  wire                ctrBPin,
    input  wire [ARRAY_AW-1:0] memWrAddr,
    input  wire                memWrReq,
    output reg                 memWrAllow,
    output reg                 backupChargeEn,
    output reg  [1:0]          supplyTripSel,
    output reg                 wdogEnable,
    output reg  [4:0]          wdogPeriod,
    output reg  [63:0]         serialNumber,
    output reg                 serialLock
);
    reg  [7:0]  wdogCtrl_reg;
    reg  [7:0]  compCtrl_reg;
    reg  [7:0]  evtCtrl_reg;
    reg  [63:0] serial_reg;
    reg  [15:0] snapA_reg;
    reg  [15:0] snapB_reg;
    reg  [7:0]  rdData_next;
    reg         allow_next;
    wire [15:0] countA;
    wire [15:0] countB;
    wire        carryA;
    wire        cascade;
    wire        locked;
    wire        wrWdog;
    wire        wrComp;
    wire        wrEvt;
    wire        wrSerial;
    wire [2:0]  serialIdx;
    wire [1:0]  protSel;
    wire        serialHit;
    wire        wrCtrALo;
    wire        wrCtrAHi;
    wire        wrCtrBLo;
    wire        wrCtrBHi;

    assign cascade   = evtCtrl_reg[`EVT_CASC_BIT];
    assign locked    = compCtrl_reg[`COMP_LOCK_BIT];
    assign protSel   = compCtrl_reg[`COMP_PROT_HI:`COMP_PROT_LO];
    assign wrWdog    = regWrEn & (regAddr == `ADDR_WDOG_CTRL);
    assign wrComp    = regWrEn & (regAddr == `ADDR_COMP_CTRL);
    assign wrEvt     = regWrEn & (regAddr == `ADDR_EVT_CTRL);
    assign serialHit = (regAddr >= `ADDR_SERIAL_LO) & (regAddr <= `ADDR_SERIAL_HI);
    assign wrSerial  = regWrEn & ~locked & serialHit; // see RULE5
    assign serialIdx = regAddr[2:0] - `SERIAL_IDX_BIAS;
    // Counter bytes load the live count; reads return the last snapshot instead
    assign wrCtrALo  = regWrEn & (regAddr == `ADDR_CTRA_LO);
    assign wrCtrAHi  = regWrEn & (regAddr == `ADDR_CTRA_HI);
    assign wrCtrBLo  = regWrEn & (regAddr == `ADDR_CTRB_LO);
    assign wrCtrBHi  = regWrEn & (regAddr == `ADDR_CTRB_HI);

    // Counter A always follows its own pin
    edge_counter #(
        .W (16)
    ) ctrA (
        .sys_clk     (sys_clk),
        .reset       (reset),
        .pinIn       (ctrAPin),
        .risingSel   (evtCtrl_reg[`EVT_APOL_BIT]),
        .cascadeMode (1'b0),
        .extStep     (1'b0),
        .wrLo        (wrCtrALo),
        .wrHi        (wrCtrAHi),
        .wrData      (regWrData),
        .count       (countA),
        .carry       (carryA)
    ); // see RULE3

    // Counter B takes A's carry in cascade; its own pin is then ignored
    edge_counter #(
        .W (16)
    ) ctrB (
        .sys_clk     (sys_clk),
        .reset       (reset),
        .pinIn       (ctrBPin),
        .risingSel   (evtCtrl_reg[`EVT_BPOL_BIT]),
        .cascadeMode (cascade),
        .extStep     (carryA),
        .wrLo        (wrCtrBLo),
        .wrHi        (wrCtrBHi),
        .wrData      (regWrData),
        .count       (countB),
        .carry       ()
    ); // see RULE1 RULE2 RULE4

    always @(posedge sys_clk) begin
        if (reset) begin
            wdogCtrl_reg <= `RST_BYTE;
            compCtrl_reg <= `RST_BYTE;
            evtCtrl_reg  <= `RST_BYTE;
        end else begin
            if (wrWdog) begin
                wdogCtrl_reg <= {regWrData[`WDOG_EN_BIT], `RSVD_PAIR,
                                 regWrData[`WDOG_PER_HI:`WDOG_PER_LO]};
            end
            if (wrComp) begin
                // Lock is sticky: once set a write can neither clear it nor change it
                compCtrl_reg[`COMP_LOCK_BIT] <= locked | regWrData[`COMP_LOCK_BIT]; // see RULE5
                compCtrl_reg[`COMP_RSVD_HI:`COMP_RSVD_LO] <= `RSVD_PAIR;
                compCtrl_reg[`COMP_PROT_HI:`COMP_PROT_LO] <=
                    regWrData[`COMP_PROT_HI:`COMP_PROT_LO]; // see RULE7
                compCtrl_reg[`COMP_CHG_BIT] <= regWrData[`COMP_CHG_BIT]; // see RULE6
                compCtrl_reg[`COMP_TRIP_HI:`COMP_TRIP_LO] <=
                    regWrData[`COMP_TRIP_HI:`COMP_TRIP_LO];
            end
            if (wrEvt) begin
                evtCtrl_reg <= {`RSVD_NIBBLE, regWrData[`EVT_SNAP_BIT:`EVT_APOL_BIT]};
            end else begin
                evtCtrl_reg[`EVT_SNAP_BIT] <= `RST_BIT;
            end
        end
    end

    // Snapshot bit stays set for one cycle, then the copy is taken and it clears
    always @(posedge sys_clk) begin
        if (reset) begin
            snapA_reg <= `RST_COUNT;
            snapB_reg <= `RST_COUNT;
        end else if (evtCtrl_reg[`EVT_SNAP_BIT]) begin
            snapA_reg <= countA;
            snapB_reg <= countB;
        end
    end

    // Serial bytes freeze once the lock is set
    always @(posedge sys_clk) begin
        if (reset) begin
            serial_reg <= `RST_SERIAL;
        end else if (wrSerial) begin
            serial_reg[serialIdx*8 +: 8] <= regWrData; // see RULE5
        end
    end

    always @* begin
        rdData_next = `RD_UNMAPPED;
        case (regAddr)
            `ADDR_WDOG_CTRL: rdData_next = wdogCtrl_reg;
            `ADDR_COMP_CTRL: rdData_next = compCtrl_reg;
            `ADDR_EVT_CTRL:  rdData_next = evtCtrl_reg;
            `ADDR_CTRA_LO:   rdData_next = snapA_reg[7:0];
            `ADDR_CTRA_HI:   rdData_next = snapA_reg[15:8];
            `ADDR_CTRB_LO:   rdData_next = snapB_reg[7:0];
            `ADDR_CTRB_HI:   rdData_next = snapB_reg[15:8];
            default: begin
                if (serialHit) begin
                    rdData_next = serial_reg[serialIdx*8 +: 8];
                end
            end
        endcase
    end

    // Protected region always starts at array address zero
    always @* begin
        allow_next = memWrReq;
        case (protSel)
            `PROT_NONE:    allow_next = memWrReq;
            `PROT_QUARTER: allow_next = memWrReq & (memWrAddr[ARRAY_AW-1:ARRAY_AW-2] != 2'h0);
            `PROT_HALF:    allow_next = memWrReq & memWrAddr[ARRAY_AW-1];
            `PROT_FULL:    allow_next = 1'b0;
            default:       allow_next = 1'b0;
        endcase
    end // see RULE7

    // Read data holds between reads, so the front end may fetch it late
    always @(posedge sys_clk) begin
        if (reset) begin
            regRdData <= `RD_UNMAPPED;
        end else if (regRdEn) begin
            regRdData <= rdData_next;
        end
    end

    // Gating is registered: the array sees the answer one cycle after its request
    always @(posedge sys_clk) begin
        if (reset) begin
            memWrAllow <= `RST_BIT;
        end else begin
            memWrAllow <= allow_next; // see RULE7
        end
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            backupChargeEn <= `RST_BIT;
            supplyTripSel  <= `RST_TRIP;
            wdogEnable     <= `RST_BIT;
            wdogPeriod     <= `RST_PERIOD;
            serialNumber   <= `RST_SERIAL;
            serialLock     <= `RST_BIT;
        end else begin
            backupChargeEn <= compCtrl_reg[`COMP_CHG_BIT]; // see RULE6
            supplyTripSel  <= compCtrl_reg[`COMP_TRIP_HI:`COMP_TRIP_LO];
            wdogEnable     <= wdogCtrl_reg[`WDOG_EN_BIT];
            wdogPeriod     <= wdogCtrl_reg[`WDOG_PER_HI:`WDOG_PER_LO];
            serialNumber   <= serial_reg;
            serialLock     <= locked;
        end
    end
endmodule
`default_nettype wire

// ===== bench/companion_checker.sv
`timescale 1ns/1ps
`default_nettype none
module companion_checker (
    input wire logic        sys_clk,
    input wire logic        reset,
    input wire logic [7:0]  regAddr,
    input wire logic [7:0]  regWrData,
    input wire logic        regWrEn,
    input wire logic        regRdEn,
    input wire logic [7:0]  regRdData,
    input wire logic        memWrReq,
    input wire logic        memWrAllow,
    input wire logic        backupChargeEn,
    input wire logic [63:0] serialNumber,
    input wire logic        serialLock
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    logic [1:0] protSel_reg;
    logic       ctlWr;
    assign ctlWr = regWrEn && regAddr == 8'h0B;
    // Shadow of the protection code, so array gating can be judged from the port
    always @(posedge sys_clk) begin
        if (reset) protSel_reg <= 2'h0;
        else if (ctlWr) protSel_reg <= regWrData[4:3];
    end
    chk_lock_sticky: assert property (
        serialLock |=> serialLock) else $error("lock cleared");
    chk_serial_frozen: assert property (
        serialLock ##1 serialLock |-> $stable(serialNumber)) else $error("serial moved");
    chk_charge_follow: assert property (
        ctlWr ##1 !ctlWr [*3] |-> backupChargeEn == $past(regWrData[2], 3))
        else $error("charge enable wrong");
    chk_full_block: assert property (
        $past(protSel_reg) == 2'h3 && $past(protSel_reg, 2) == 2'h3 |-> !memWrAllow)
        else $error("write passed full protection");
    chk_open_pass: assert property (
        !$past(reset) && $past(memWrReq) && $past(protSel_reg) == 2'h0
        && $past(protSel_reg, 2) == 2'h0 |-> memWrAllow) else $error("write blocked");
    chk_allow_cause: assert property (
        memWrAllow |-> $past(memWrReq)) else $error("allow without request");
    chk_unmapped_rd: assert property (
        regRdEn && regAddr == 8'h30 |=> regRdData == 8'h00) else $error("unmapped read");
    chk_rd_hold: assert property (
        !regRdEn |=> $stable(regRdData)) else $error("read data moved");
    cover property (memWrReq && protSel_reg == 2'h3);
    cover property (ctlWr && serialLock);
    cover property (regRdEn && regAddr == 8'h0C);
endmodule
bind companion_control_regs companion_checker u_chk (.sys_clk, .reset, .regAddr,
    .regWrData, .regWrEn, .regRdEn, .regRdData, .memWrReq, .memWrAllow,
    .backupChargeEn, .serialNumber, .serialLock);
`default_nettype wire

// ===== bench/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic       sys_clk,
    output var  logic [7:0] regAddr,
    output var  logic [7:0] regWrData,
    output var  logic       regWrEn,
    output var  logic       regRdEn,
    input  wire logic [7:0] regRdData
);
    initial {regAddr, regWrData, regWrEn, regRdEn} = 18'h00000;
    // Strobes stand one cycle only; a longer strobe would be a second access
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #1;
        {regAddr, regWrData, regWrEn} = {a, d, 1'b1};
        @(posedge sys_clk);
        #1;
        regWrEn = 1'b0;
    endtask
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        #1;
        {regAddr, regRdEn} = {a, 1'b1};
        @(posedge sys_clk);
        #1;
        regRdEn = 1'b0;
        d = regRdData;
    endtask
endmodule
`default_nettype wire

// ===== bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        sys_clk = 1'b0;
    logic        reset = 1'b1;
    logic        ctrAPin = 1'b0, ctrBPin = 1'b0, memWrReq = 1'b0;
    logic [14:0] memWrAddr = 15'h0000;
    logic [7:0]  rdVal;
    wire  [7:0]  regAddr, regWrData, regRdData;
    wire         regWrEn, regRdEn, memWrAllow, backupChargeEn, wdogEnable, serialLock;
    wire  [1:0]  supplyTripSel;
    wire  [4:0]  wdogPeriod;
    wire  [63:0] serialNumber;
    wire  [8:0]  ctlOuts = {wdogEnable, wdogPeriod, backupChargeEn, supplyTripSel};
    int          err_count = 0, n_checks = 0;
    always #12.5 sys_clk = ~sys_clk;
    companion_control_regs #(.ARRAY_AW(15)) u_dut (.sys_clk, .reset, .regAddr, .regWrData,
        .regWrEn, .regRdEn, .regRdData, .ctrAPin, .ctrBPin, .memWrAddr, .memWrReq,
        .memWrAllow, .backupChargeEn, .supplyTripSel, .wdogEnable, .wdogPeriod,
        .serialNumber, .serialLock);
    host_model u_host (.sys_clk, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData);
    task check(input string nm, input logic [63:0] exp, input logic [63:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task rc(input logic [7:0] a, input logic [7:0] exp);
        u_host.rd(a, rdVal);
        check("regRdData", {56'h0, exp}, {56'h0, rdVal});
    endtask
    // Eight cycles a level keeps every edge well clear of the synchroniser
    task toggle3();
        repeat (3) begin
            repeat (8) @(posedge sys_clk);
            #1;
            {ctrAPin, ctrBPin} = ~{ctrAPin, ctrBPin};
        end
        repeat (8) @(posedge sys_clk);
    endtask
    task snap(input logic [7:0] ctl, input logic [31:0] exp);
        u_host.wr(8'h0C, ctl | 8'h08);
        for (int i = 0; i < 4; i++) begin
            u_host.rd(8'h0D + 8'(i), rdVal);
            check("counter", {56'h0, exp[8*i +: 8]}, {56'h0, rdVal});
        end
    endtask
    task summarize();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        summarize();
    end
    initial begin
        repeat (2) @(posedge sys_clk);
        #1;
        reset = 1'b0;
        check("outputs", 64'h0, {53'h0, ctlOuts, memWrAllow, serialLock});
        rc(8'h0A, 8'h00);
        rc(8'h0B, 8'h00);
        rc(8'h0C, 8'h00);
        u_host.wr(8'h30, 8'hFF);
        rc(8'h30, 8'h00);
        u_host.wr(8'h0A, 8'hFF);
        rc(8'h0A, 8'h9F);
        u_host.wr(8'h0B, 8'h67);
        rc(8'h0B, 8'h07);
        check("outputs", 64'h1FF, {55'h0, ctlOuts});
        u_host.wr(8'h0B, 8'h00);
        repeat (3) @(posedge sys_clk);
        #1;
        check("backupChargeEn", 64'h0, {63'h0, backupChargeEn});
        for (int c = 0; c < 4; c++) begin
            u_host.wr(8'h0B, {3'h0, 2'(c), 3'h0});
            for (int k = 0; k < 4; k++) begin
                @(posedge sys_clk);
                #1;
                memWrAddr = 15'h1FFF + {1'b0, k[1], 12'h000, k[0]};
                memWrReq = 1'b1;
                @(posedge sys_clk);
                #1;
                check("memWrAllow", {63'h0, k >= 2 * c - 1}, {63'h0, memWrAllow});
                memWrReq = 1'b0;
            end
        end
        u_host.wr(8'h0C, 8'h01);
        toggle3();
        snap(8'h01, 32'h0001_0002);
        u_host.wr(8'h0C, 8'h02);
        toggle3();
        snap(8'h02, 32'h0002_0004);
        rc(8'h0C, 8'h02);
        u_host.wr(8'h0D, 8'hFF);
        u_host.wr(8'h0E, 8'hFF);
        u_host.wr(8'h0F, 8'h05);
        u_host.wr(8'h10, 8'h00);
        u_host.wr(8'h0C, 8'h06);
        toggle3();
        snap(8'h06, 32'h0006_0000);
        rc(8'h0C, 8'h06);
        u_host.wr(8'h11, 8'hA5);
        u_host.wr(8'h0B, 8'h80);
        u_host.wr(8'h11, 8'h3C);
        u_host.wr(8'h0B, 8'h00);
        rc(8'h11, 8'hA5);
        rc(8'h0B, 8'h80);
        check("serialLock", 64'h1, {63'h0, serialLock});
        check("serialNumber", 64'hA5, serialNumber);
        summarize();
    end
endmodule
`default_nettype wire
